// ==== core/lookup_map.svh ====
// constants for the vlan and spanning-tree ingress lookup
`ifndef LOOKUP_MAP_SVH
`define LOOKUP_MAP_SVH
`define LK_NPORTS 65
`define LK_PIDX_W 7
`define LK_VID_W 12
`define LK_VIDX_W 13
`define LK_VLAN_DEPTH 5120
`define LK_MSTP_DEPTH 66
`define LK_PTR_W 7
`define LK_FID_W 13
`define LK_RLEG_W 9
`define LK_TAG_W 16
`define LK_VE_RLEG_LSB 0
`define LK_VE_PTR_LSB 9
`define LK_VE_FID_LSB 16
`define LK_VE_SEC_FWD 29
`define LK_VE_FLOOD_DIS 30
`define LK_VE_LRN_DIS 31
`define LK_VE_RLEG_ENA 32
`define LK_VE_PRIVATE 33
`define LK_VE_MIRROR 34
`define LK_VE_MASK_LSB 35
`define LK_VE_TAG_LSB 100
`define LK_VE_W 116
`define LK_ME_FWD_LSB 0
`define LK_ME_LRN_LSB 65
`define LK_ME_W 130
`define LK_LATENCY 3
`endif

// ==== core/lookup_pkg.sv ====
// types shared by the ingress lookup files
`include "lookup_map.svh"
package lookup_pkg;
    typedef logic [`LK_NPORTS-1:0] port_mask_t;
    typedef logic [`LK_PIDX_W-1:0] port_idx_t;
    typedef enum logic [1:0] {
        ROLE_PROMISC = 2'b00,
        ROLE_COMMUNITY = 2'b01,
        ROLE_ISOLATED = 2'b10
    } port_role_t;
endpackage

// ==== core/lookup_table.sv ====
// single-port-write, registered-read table memory
`timescale 1ns/1ps
module lookup_table #(
    parameter int DEPTH = 66,
    parameter int AW = 7,
    parameter int DW = 130
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];

    initial begin
        if (DEPTH < 1 || DEPTH > (1 << AW)) begin
            $error("table depth does not fit the address width");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // writes past the depth are dropped
    always_ff @(posedge clk) begin
        if (wr_en && (32'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // addresses past the depth read as an empty entry
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= '0;
        end else if (32'(rd_addr) < DEPTH) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end
endmodule

// ==== core/pvlan_mask.sv ====
// private vlan role of the ingress port and destination trimming
`timescale 1ns/1ps
module pvlan_mask (
    input wire logic private_ena,
    input wire logic is_isolated,
    input wire logic is_community,
    input wire lookup_pkg::port_mask_t member,
    input wire lookup_pkg::port_mask_t isolated_mask,
    input wire lookup_pkg::port_mask_t community_mask,
    output lookup_pkg::port_role_t role,
    output lookup_pkg::port_mask_t adj_mask
);
    import lookup_pkg::*;

    // isolated wins over community when both are set
    always_comb begin
        role = ROLE_PROMISC;
        if (is_community) begin
            role = ROLE_COMMUNITY;
        end
        if (is_isolated) begin
            role = ROLE_ISOLATED;
        end
    end

    always_comb begin
        adj_mask = member;
        if (private_ena) begin
            unique case (role)
                ROLE_ISOLATED: adj_mask = member & ~isolated_mask & ~community_mask;
                ROLE_COMMUNITY: adj_mask = member & ~isolated_mask;
                default: adj_mask = member;
            endcase
        end
    end
endmodule

// ==== core/vlan_mstp_ingress_lookup.sv ====
// ingress vlan and spanning-tree lookup pipeline
// What this block does
// - with lookup enabled, the classified vid indexes the vlan table
// - vlan table holds 5120 entries selected by the lookup index
// - each vlan entry's 7-bit pointer addresses the spanning-tree table
// - spanning-tree table holds 66 entries addressed by that pointer
// - learn and forward results combine vlan and spanning-tree entries; mirror uses the vlan entry only
// - the 13-bit filtering id is output for learning and forwarding
// - the 9-bit router-leg id is passed on with the frame
// - a 1-bit router-leg enable marks routing enabled for the vlan
// - secure forwarding forwards only frames with a known source address
// - flood disable stops flooding of unknown-destination frames
// - learn disable suppresses source learning in that vlan
// - private flag makes the vlan private, enabling isolated/community handling
// - mirror flag marks frames of that ingress vlan for mirroring
// - each entry holds a 65-bit port membership mask
// - each entry carries a 16-bit tag for bulk table updates
// - cleared spanning-tree forward bit blocks forwarding from that port
// - cleared spanning-tree learn bit suppresses learning from that port
// - common forward mask gates ingress forwarding and destinations
// - common learn mask suppresses learning from cleared ports
// - ingress filter drops and unlearns frames from non-member ports
// - isolated and community masks classify ports; neither means promiscuous
// - lookup disabled uses all-ones masks and zero other fields
// - isolated ingress in a private vlan reaches promiscuous ports only
// - community ingress in a private vlan excludes isolated ports
// - destination mask is adjusted membership and the common and spanning-tree forward masks
`timescale 1ns/1ps
`include "lookup_map.svh"
module vlan_mstp_ingress_lookup #(
    parameter int VLAN_DEPTH = `LK_VLAN_DEPTH,
    parameter int MSTP_DEPTH = `LK_MSTP_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic vlan_ena,
    input wire lookup_pkg::port_mask_t port_fwd_ena,
    input wire lookup_pkg::port_mask_t port_lrn_ena,
    input wire lookup_pkg::port_mask_t igr_filter_ena,
    input wire lookup_pkg::port_mask_t isolated_mask,
    input wire lookup_pkg::port_mask_t community_mask,
    input wire logic mirror_probe_ena,
    input wire logic vlan_wr_en,
    input wire logic [`LK_VIDX_W-1:0] vlan_wr_addr,
    input wire logic [`LK_VE_W-1:0] vlan_wr_data,
    input wire logic mstp_wr_en,
    input wire logic [`LK_PTR_W-1:0] mstp_wr_addr,
    input wire logic [`LK_ME_W-1:0] mstp_wr_data,
    input wire logic req_valid,
    input wire logic [`LK_VID_W-1:0] req_vid,
    input wire logic req_vid_ext,
    input wire lookup_pkg::port_idx_t req_port,
    input wire logic req_smac_known,
    input wire logic req_dmac_unknown,
    output logic out_valid,
    output lookup_pkg::port_mask_t out_dest_mask,
    output logic [`LK_FID_W-1:0] out_fid,
    output logic [`LK_RLEG_W-1:0] out_rleg_id,
    output logic out_rleg_ena,
    output logic out_fwd,
    output logic out_learn,
    output logic out_mirror,
    output logic out_flood_dis,
    output logic out_sec_fwd,
    output lookup_pkg::port_role_t out_role,
    output logic [`LK_TAG_W-1:0] out_bulk_tag
);
    import lookup_pkg::*;

    initial begin
        if (VLAN_DEPTH < 1 || VLAN_DEPTH > (1 << `LK_VIDX_W)) begin
            $error("vlan table depth out of range");
        end
        if (MSTP_DEPTH < 1 || MSTP_DEPTH > (1 << `LK_PTR_W)) begin
            $error("spanning-tree table depth out of range");
        end
    end

    // out-of-range port numbers read as a cleared bit
    function automatic logic port_bit(input port_mask_t m, input port_idx_t p);
        port_bit = (32'(p) < `LK_NPORTS) ? m[p] : 1'b0;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // stage 1: vlan table read
    logic s1_valid_r;
    logic s1_ena_r;
    port_idx_t s1_port_r;
    logic s1_smac_r;
    logic s1_dunk_r;
    logic [`LK_VIDX_W-1:0] vlan_rd_addr;
    logic [`LK_VE_W-1:0] vlan_rd_data;
    logic [`LK_VE_W-1:0] vlan_s1;
    logic [`LK_ME_W-1:0] mstp_rd_data;

    // extension bit selects entries 4096 and up
    assign vlan_rd_addr = {req_vid_ext, req_vid};

    lookup_table #(
        .DEPTH(VLAN_DEPTH),
        .AW(`LK_VIDX_W),
        .DW(`LK_VE_W)
    ) u_vlan_tbl (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(vlan_wr_en),
        .wr_addr(vlan_wr_addr),
        .wr_data(vlan_wr_data),
        .rd_addr(vlan_rd_addr),
        .rd_data(vlan_rd_data)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_valid_r <= 1'b0;
            s1_ena_r <= 1'b0;
            s1_port_r <= '0;
            s1_smac_r <= 1'b0;
            s1_dunk_r <= 1'b0;
        end else begin
            s1_valid_r <= req_valid;
            s1_ena_r <= vlan_ena;
            s1_port_r <= req_port;
            s1_smac_r <= req_smac_known;
            s1_dunk_r <= req_dmac_unknown;
        end
    end

    // default entry when lookup is off: every port a member, rest zero
    always_comb begin
        vlan_s1 = '0;
        vlan_s1[`LK_VE_MASK_LSB +: `LK_NPORTS] = '1;
        if (s1_ena_r) begin
            vlan_s1 = vlan_rd_data;
        end
    end

    lookup_table #(
        .DEPTH(MSTP_DEPTH),
        .AW(`LK_PTR_W),
        .DW(`LK_ME_W)
    ) u_mstp_tbl (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(mstp_wr_en),
        .wr_addr(mstp_wr_addr),
        .wr_data(mstp_wr_data),
        .rd_addr(vlan_s1[`LK_VE_PTR_LSB +: `LK_PTR_W]),
        .rd_data(mstp_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // stage 2: spanning-tree read, vlan entry held alongside
    logic s2_valid_r;
    logic s2_ena_r;
    port_idx_t s2_port_r;
    logic s2_smac_r;
    logic s2_dunk_r;
    logic [`LK_VE_W-1:0] s2_vlan_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s2_valid_r <= 1'b0;
            s2_ena_r <= 1'b0;
            s2_port_r <= '0;
            s2_smac_r <= 1'b0;
            s2_dunk_r <= 1'b0;
            s2_vlan_r <= '0;
        end else begin
            s2_valid_r <= s1_valid_r;
            s2_ena_r <= s1_ena_r;
            s2_port_r <= s1_port_r;
            s2_smac_r <= s1_smac_r;
            s2_dunk_r <= s1_dunk_r;
            s2_vlan_r <= vlan_s1;
        end
    end

    port_mask_t member;
    port_mask_t mstp_fwd;
    port_mask_t mstp_lrn;
    logic lrn_dis;
    logic private_ena;
    logic flood_dis;
    logic sec_fwd;
    logic mirror_flag;

    assign member = s2_vlan_r[`LK_VE_MASK_LSB +: `LK_NPORTS];
    assign lrn_dis = s2_vlan_r[`LK_VE_LRN_DIS];
    assign private_ena = s2_vlan_r[`LK_VE_PRIVATE];
    assign flood_dis = s2_vlan_r[`LK_VE_FLOOD_DIS];
    assign sec_fwd = s2_vlan_r[`LK_VE_SEC_FWD];
    assign mirror_flag = s2_vlan_r[`LK_VE_MIRROR];
    // disabled lookup sees all-ones spanning-tree masks
    assign mstp_fwd = s2_ena_r ? mstp_rd_data[`LK_ME_FWD_LSB +: `LK_NPORTS] : '1;
    assign mstp_lrn = s2_ena_r ? mstp_rd_data[`LK_ME_LRN_LSB +: `LK_NPORTS] : '1;

    port_role_t role;
    port_mask_t pv_mask;

    pvlan_mask u_pvlan (
        .private_ena(private_ena),
        .is_isolated(port_bit(isolated_mask, s2_port_r)),
        .is_community(port_bit(community_mask, s2_port_r)),
        .member(member),
        .isolated_mask(isolated_mask),
        .community_mask(community_mask),
        .role(role),
        .adj_mask(pv_mask)
    );

    ////////////////////////////////////////////////////////////////////////
    // decision
    logic fwd_nxt;
    logic lrn_nxt;
    logic filtered;
    port_mask_t mask_nxt;
    port_mask_t dest_nxt;

    assign filtered = s2_ena_r && port_bit(igr_filter_ena, s2_port_r)
        && !port_bit(member, s2_port_r);

    always_comb begin
        fwd_nxt = 1'b1;
        lrn_nxt = 1'b1;
        mask_nxt = member;
        if (!port_bit(port_fwd_ena, s2_port_r)) begin
            fwd_nxt = 1'b0;
        end
        if (!port_bit(port_lrn_ena, s2_port_r)) begin
            lrn_nxt = 1'b0;
        end
        if (filtered) begin
            fwd_nxt = 1'b0;
            lrn_nxt = 1'b0;
        end else if (s2_ena_r) begin
            if (!port_bit(mstp_fwd, s2_port_r)) begin
                fwd_nxt = 1'b0;
            end
            if (lrn_dis || !port_bit(mstp_lrn, s2_port_r)) begin
                lrn_nxt = 1'b0;
            end
            mask_nxt = pv_mask;
        end
        // secure vlan: unknown sources go nowhere
        if (sec_fwd && !s2_smac_r) begin
            fwd_nxt = 1'b0;
        end
    end

    // destinations limited to ports in forwarding state
    always_comb begin
        dest_nxt = mask_nxt & port_fwd_ena & mstp_fwd;
        if (flood_dis && s2_dunk_r) begin
            dest_nxt = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stage 3: registered results
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            out_dest_mask <= '0;
            out_fwd <= 1'b0;
            out_learn <= 1'b0;
            out_role <= ROLE_PROMISC;
        end else begin
            out_valid <= s2_valid_r;
            out_dest_mask <= dest_nxt;
            out_fwd <= fwd_nxt;
            out_learn <= lrn_nxt;
            out_role <= (s2_ena_r && private_ena) ? role : ROLE_PROMISC;
        end
    end

    // vlan attributes passed straight through, mirror flag gated by the probe enable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_fid <= '0;
            out_rleg_id <= '0;
            out_rleg_ena <= 1'b0;
            out_mirror <= 1'b0;
            out_flood_dis <= 1'b0;
            out_sec_fwd <= 1'b0;
            out_bulk_tag <= '0;
        end else begin
            out_fid <= s2_vlan_r[`LK_VE_FID_LSB +: `LK_FID_W];
            out_rleg_id <= s2_vlan_r[`LK_VE_RLEG_LSB +: `LK_RLEG_W];
            out_rleg_ena <= s2_vlan_r[`LK_VE_RLEG_ENA];
            // no probe, no vlan mirroring
            out_mirror <= mirror_flag && mirror_probe_ena;
            out_flood_dis <= flood_dis;
            out_sec_fwd <= sec_fwd;
            out_bulk_tag <= s2_vlan_r[`LK_VE_TAG_LSB +: `LK_TAG_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_latency;
        @(posedge clk) disable iff (!reset_n)
        req_valid |-> ##3 out_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("result missing 3 cycles after request");
    property p_no_spurious;
        @(posedge clk) disable iff (!reset_n)
        !req_valid |-> ##3 !out_valid;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("result without request");
    property p_default_entry;
        @(posedge clk) disable iff (!reset_n)
        (req_valid && !vlan_ena) |-> ##3 (out_fid == '0 && out_rleg_id == '0 && !out_rleg_ena
            && !out_mirror && out_bulk_tag == '0);
    endproperty
    a_default_entry: assert property (p_default_entry) else $error("default entry not zero");
    property p_dest_fwd_state;
        @(posedge clk) disable iff (!reset_n)
        s2_valid_r |=> (out_dest_mask & ~$past(port_fwd_ena)) == '0;
    endproperty
    a_dest_fwd_state: assert property (p_dest_fwd_state) else $error("dest on blocked port");
    property p_igr_fwd_state;
        @(posedge clk) disable iff (!reset_n)
        (s2_valid_r && !port_bit(port_fwd_ena, s2_port_r)) |=> !out_fwd;
    endproperty
    a_igr_fwd_state: assert property (p_igr_fwd_state) else $error("forward from blocked port");
    property p_lrn_state;
        @(posedge clk) disable iff (!reset_n)
        (s2_valid_r && !port_bit(port_lrn_ena, s2_port_r)) |=> !out_learn;
    endproperty
    a_lrn_state: assert property (p_lrn_state) else $error("learn from blocked port");
    property p_ingress_filter;
        @(posedge clk) disable iff (!reset_n)
        (s2_valid_r && filtered) |=> (!out_fwd && !out_learn);
    endproperty
    a_ingress_filter: assert property (p_ingress_filter) else $error("filtered frame passed");
    property p_vlan_lrn_dis;
        @(posedge clk) disable iff (!reset_n)
        (s2_valid_r && s2_ena_r && lrn_dis) |=> !out_learn;
    endproperty
    a_vlan_lrn_dis: assert property (p_vlan_lrn_dis) else $error("learned in learn-off vlan");
    property p_mstp_fwd;
        @(posedge clk) disable iff (!reset_n)
        (s2_valid_r && s2_ena_r && !port_bit(mstp_fwd, s2_port_r)) |=> !out_fwd;
    endproperty
    a_mstp_fwd: assert property (p_mstp_fwd) else $error("forward from discarding port");

    property p_mirror_probe;
        @(posedge clk) disable iff (!reset_n)
        (s2_valid_r && !mirror_probe_ena) |=> !out_mirror;
    endproperty
    a_mirror_probe: assert property (p_mirror_probe) else $error("mirror without probe");

    property p_isolated;
        @(posedge clk) disable iff (!reset_n)
        (s2_valid_r && s2_ena_r && !filtered && private_ena
            && port_bit(isolated_mask, s2_port_r))
        |=> (out_dest_mask & ($past(isolated_mask) | $past(community_mask))) == '0;
    endproperty
    a_isolated: assert property (p_isolated) else $error("isolated port reaches non-promisc");

    property p_flood_dis;
        @(posedge clk) disable iff (!reset_n)
        (s2_valid_r && flood_dis && s2_dunk_r) |=> out_dest_mask == '0;
    endproperty
    a_flood_dis: assert property (p_flood_dis) else $error("flooded in flood-off vlan");
endmodule

// ==== bench/frame_source.sv ====
// upstream classifier stand-in: launches one frame request per clock cycle that fire is high
`timescale 1ns/1ps
module frame_source (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic fire,
    input wire logic [12:0] idx,
    input wire logic [6:0] port,
    input wire logic sk,
    input wire logic du,
    output logic req_valid,
    output logic [11:0] req_vid,
    output logic req_vid_ext,
    output lookup_pkg::port_idx_t req_port,
    output logic req_smac_known,
    output logic req_dmac_unknown
);
    import lookup_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // fields invert while idle so a stale value never passes for a frame
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            req_valid <= 1'b0;
            req_vid <= '0;
            req_vid_ext <= 1'b0;
            req_port <= '0;
            req_smac_known <= 1'b0;
            req_dmac_unknown <= 1'b0;
        end else if (fire) begin
            req_valid <= 1'b1;
            req_vid <= idx[11:0];
            req_vid_ext <= idx[12];
            req_port <= port;
            req_smac_known <= sk;
            req_dmac_unknown <= du;
        end else begin
            req_valid <= 1'b0;
            req_vid <= ~req_vid;
            req_vid_ext <= ~req_vid_ext;
            req_port <= ~req_port;
            req_smac_known <= ~req_smac_known;
            req_dmac_unknown <= ~req_dmac_unknown;
        end
    end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the ingress vlan and spanning-tree lookup
`timescale 1ns/1ps
`include "lookup_map.svh"
module testbench;
    import lookup_pkg::*;
    localparam int VD = `LK_VLAN_DEPTH;
    localparam int MD = `LK_MSTP_DEPTH;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic vlan_ena = 1'b1;
    port_mask_t port_fwd_ena = '1;
    port_mask_t port_lrn_ena = '1;
    port_mask_t igr_filter_ena = '0;
    port_mask_t isolated_mask = '0;
    port_mask_t community_mask = '0;
    logic mirror_probe_ena = 1'b0;
    logic vlan_wr_en = 1'b0;
    logic [12:0] vlan_wr_addr = '0;
    logic [115:0] vlan_wr_data = '0;
    logic mstp_wr_en = 1'b0;
    logic [6:0] mstp_wr_addr = '0;
    logic [129:0] mstp_wr_data = '0;
    logic fire = 1'b0;
    logic [12:0] f_idx = '0;
    logic [6:0] f_port = '0;
    logic f_sk = 1'b0;
    logic f_du = 1'b0;
    logic req_valid, req_vid_ext, req_smac_known, req_dmac_unknown;
    logic [11:0] req_vid;
    port_idx_t req_port;
    logic out_valid, out_rleg_ena, out_fwd, out_learn, out_mirror, out_flood_dis, out_sec_fwd;
    port_mask_t out_dest_mask;
    logic [12:0] out_fid;
    logic [8:0] out_rleg_id;
    port_role_t out_role;
    logic [15:0] out_bulk_tag;
    logic [115:0] vtab [int];
    logic [129:0] mtab [int];
    logic [110:0] expq [$];
    int dueq [$];
    int vix [8];
    int cyc = 0;
    int n_errors = 0;
    int checked = 0;
    integer seed = 32'h847f;
    always #50 clk = ~clk;
    frame_source u_frame_source (.clk(clk), .reset_n(reset_n), .fire(fire), .idx(f_idx),
        .port(f_port), .sk(f_sk), .du(f_du), .req_valid(req_valid), .req_vid(req_vid),
        .req_vid_ext(req_vid_ext), .req_port(req_port), .req_smac_known(req_smac_known),
        .req_dmac_unknown(req_dmac_unknown));
    vlan_mstp_ingress_lookup u_vlan_mstp_ingress_lookup (.clk(clk), .reset_n(reset_n),
        .vlan_ena(vlan_ena), .port_fwd_ena(port_fwd_ena), .port_lrn_ena(port_lrn_ena),
        .igr_filter_ena(igr_filter_ena), .isolated_mask(isolated_mask),
        .community_mask(community_mask), .mirror_probe_ena(mirror_probe_ena),
        .vlan_wr_en(vlan_wr_en), .vlan_wr_addr(vlan_wr_addr), .vlan_wr_data(vlan_wr_data),
        .mstp_wr_en(mstp_wr_en), .mstp_wr_addr(mstp_wr_addr), .mstp_wr_data(mstp_wr_data),
        .req_valid(req_valid), .req_vid(req_vid), .req_vid_ext(req_vid_ext),
        .req_port(req_port), .req_smac_known(req_smac_known),
        .req_dmac_unknown(req_dmac_unknown), .out_valid(out_valid),
        .out_dest_mask(out_dest_mask), .out_fid(out_fid), .out_rleg_id(out_rleg_id),
        .out_rleg_ena(out_rleg_ena), .out_fwd(out_fwd), .out_learn(out_learn),
        .out_mirror(out_mirror), .out_flood_dis(out_flood_dis), .out_sec_fwd(out_sec_fwd),
        .out_role(out_role), .out_bulk_tag(out_bulk_tag));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [127:0] r128();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction
    function automatic logic pb(input port_mask_t mk, input logic [6:0] p);
        return (p < 7'd65) ? mk[p] : 1'b0;
    endfunction
    function automatic logic [110:0] expect_out(input logic [12:0] ix, input logic [6:0] p,
            input logic sk, input logic du);
        logic [115:0] v;
        logic [129:0] m;
        port_mask_t mask;
        logic f, l;
        logic [1:0] role;
        v = (vlan_ena && ix < VD && vtab.exists(ix)) ? vtab[ix] : '0;
        m = !vlan_ena ? '1 : (v[15:9] < MD) ? mtab[v[15:9]] : '0;
        mask = vlan_ena ? v[99:35] : '1;
        f = pb(port_fwd_ena, p);
        l = pb(port_lrn_ena, p);
        // the port role is reported for every private-vlan lookup, filtered or not
        role = 2'b00;
        if (vlan_ena && v[33]) begin
            role = pb(isolated_mask, p) ? 2'b10 : {1'b0, pb(community_mask, p)};
        end
        if (vlan_ena && pb(igr_filter_ena, p) && !pb(mask, p)) begin
            f = 1'b0;
            l = 1'b0;
        end else if (vlan_ena) begin
            f &= pb(m[64:0], p);
            l &= !v[31] && pb(m[129:65], p);
            mask &= (role == 2'b10) ? ~isolated_mask & ~community_mask : '1;
            mask &= (role == 2'b01) ? ~isolated_mask : '1;
        end
        f &= !(v[29] && !sk);
        mask = (v[30] && du) ? '0 : mask & port_fwd_ena & m[64:0];
        return {mask, v[28:16], v[8:0], v[32], f, l, v[34] && mirror_probe_ena,
            v[30], v[29], role, v[115:100]};
    endfunction
    task automatic chk(input string what, input logic [110:0] e, input logic [110:0] a);
        checked++;
        if (a !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", what, e, a);
        end
    endtask
    task automatic drive(input logic v, input logic m, input logic f);
        @(posedge clk);
        vlan_wr_en <= v;
        mstp_wr_en <= m;
        fire <= f;
    endtask
    task automatic vwr(input logic [12:0] a, input logic [115:0] d);
        drive(1'b1, 1'b0, 1'b0);
        vlan_wr_addr <= a;
        vlan_wr_data <= d;
        if (a < VD) vtab[a] = d;
    endtask
    task automatic mwr(input logic [6:0] a, input logic [129:0] d);
        drive(1'b0, 1'b1, 1'b0);
        mstp_wr_addr <= a;
        mstp_wr_data <= d;
        if (a < MD) mtab[a] = d;
    endtask
    task automatic frm(input logic [12:0] ix);
        drive(1'b0, 1'b0, 1'b1);
        f_idx <= ix;
        f_port <= 7'($unsigned($random(seed)) % 72);
        f_sk <= 1'($random(seed));
        f_du <= 1'($random(seed));
    endtask
    function automatic logic [115:0] ventry();
        logic [127:0] t;
        t = r128();
        t[15:9] = 7'($unsigned($random(seed)) % 68);
        return t[115:0];
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // scoreboard: results must come back in order, three sampling edges after the request
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            expq.delete();
            dueq.delete();
        end else begin
            cyc++;
            if (out_valid !== 1'b0) begin
                chk("latency", (dueq.size() > 0) ? dueq[0] : -1, cyc);
                chk("result", (expq.size() > 0) ? expq[0] : '1, {out_dest_mask, out_fid,
                    out_rleg_id, out_rleg_ena, out_fwd, out_learn, out_mirror, out_flood_dis,
                    out_sec_fwd, out_role, out_bulk_tag});
                void'(expq.pop_front());
                void'(dueq.pop_front());
            end
            if (req_valid === 1'b1) begin
                expq.push_back(expect_out({req_vid_ext, req_vid}, req_port, req_smac_known,
                    req_dmac_unknown));
                dueq.push_back(cyc + 3);
            end
        end
    end
    initial begin
        #(30000 * 100);
        n_errors++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [115:0] d;
        repeat (4) @(posedge clk);
        chk("reset valid", 0, out_valid);
        reset_n <= 1'b1;
        vix = '{0, 4095, 4096, 5119, 17, 1023, 2222, 3333};
        for (int i = 0; i < 66; i++) mwr(7'(i), {r128(), 2'($random(seed))});
        mwr(7'd127, '0);
        foreach (vix[i]) vwr(13'(vix[i]), ventry());
        vwr(13'd8191, '1);
        $display("tables loaded");
        for (int rnd = 0; rnd < 8; rnd++) begin
            drive(1'b0, 1'b0, 1'b0);
            repeat (6) @(posedge clk);
            vlan_ena <= (rnd != 1);
            port_fwd_ena <= (rnd == 0) ? '1 : 65'(r128() | r128());
            port_lrn_ena <= 65'(r128() | r128());
            igr_filter_ena <= 65'(r128());
            isolated_mask <= 65'(r128() & r128());
            community_mask <= 65'(r128());
            mirror_probe_ena <= rnd[0];
            d = ventry();
            vwr(13'(vix[rnd]), d);
            mwr((d[15:9] < MD) ? d[15:9] : 7'd127, {r128(), 2'b11});
            frm(13'(vix[rnd]));
            for (int k = 0; k < 24; k++) begin
                frm(($random(seed) % 7 == 0) ? 13'(5120 + rnd * 383) : 13'(vix[k % 8]));
            end
            if (rnd == 5) begin
                drive(1'b0, 1'b0, 1'b0);
                #30 reset_n = 1'b0;
                @(posedge clk);
                #1 chk("reset dest", 0, {out_valid, out_dest_mask});
                @(posedge clk);
                reset_n <= 1'b1;
            end
            $display("round %0d done", rnd);
        end
        drive(1'b0, 1'b0, 1'b0);
        repeat (8) @(posedge clk);
        chk("pending", 0, expq.size());
        results();
    end
endmodule
